// [src/cmp_ctrl_pkg.sv]
package cmp_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_CONFIG = 3'h0;
    localparam logic [2:0] IDX_ROUTE = 3'h1;
    localparam logic [2:0] IDX_IRQEN = 3'h2;
    localparam logic [2:0] IDX_STATUS = 3'h3;
    localparam logic [2:0] IDX_RSVD_LO = 3'h4;
    localparam logic [2:0] IDX_RSVD_HI = 3'h7;

    // Field positions
    localparam int unsigned CFG_ENABLE_BIT = 7;
    localparam int unsigned CFG_PIN_EN_BIT = 6;
    localparam int unsigned CFG_POL_BIT = 5;
    localparam int unsigned CFG_FSPEED_BIT = 4;
    localparam int unsigned CFG_HYST_LSB = 2;
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned ROUTE_POS_LSB = 4;
    localparam int unsigned ROUTE_NEG_LSB = 0;
    localparam int unsigned IRQEN_BIT = 0;
    localparam int unsigned STAT_RESULT_BIT = 7;
    localparam int unsigned STAT_FLAG_BIT = 0;

    // Reset values
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic IRQEN_RST = 1'b0;
    localparam logic HELD_RST = 1'b0;

    // Timing in bus clock cycles
    localparam int unsigned SETTLE_CYCLES = 127;
    localparam int unsigned FLAG_LAG_CYCLES = 2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EDGE_NONE = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_mode_t;

endpackage

// [src/cmp_result_path.sv]
`timescale 1ns/1ns
module cmp_result_path
    import cmp_ctrl_pkg::*;
#(
    parameter int unsigned CNT_W = 7,
    parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Comparator side
    input wire logic raw_in,
    input wire logic oper_in,
    // Result path
    output logic held_out,
    output logic settled_out,
    output logic rise_out,
    output logic fall_out
);

    generate
        if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CNT_W))
        begin : g_bad_settle
            $error("SETTLE_CYC does not fit CNT_W");
        end
    endgenerate

    logic sync1_ff;
    logic sync2_ff;
    logic held_ff;
    logic d1_ff;
    logic d2_ff;
    logic d3_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic settled;

    assign settled = (cnt_ff == CNT_W'(SETTLE_CYC));
    assign nxt_cnt = !oper_in ? '0 : (settled ? cnt_ff : cnt_ff + 1'b1);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            held_ff <= HELD_RST;
        else if (oper_in && settled)
            held_ff <= sync2_ff;
    end

    // Edge chain delays flag two clocks past the pin
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            d1_ff <= HELD_RST;
            d2_ff <= HELD_RST;
            d3_ff <= HELD_RST;
        end
        else
        begin
            d1_ff <= held_ff;
            d2_ff <= d1_ff;
            d3_ff <= d2_ff;
        end
    end

    assign held_out = held_ff;
    assign settled_out = settled;
    assign rise_out = d2_ff && !d3_ff;
    assign fall_out = !d2_ff && d3_ff;

endmodule

// [src/comparator_control_logic.sv]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module comparator_control_logic
    import cmp_ctrl_pkg::*;
#(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
)
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Analog core
    input wire logic CMP_RAW_IN,
    input wire logic STOP_MODE_IN,
    output logic CMP_POWER_OUT,
    output logic INPUT_CONNECT_OUT,
    output logic FILTER_SPEED_OUT,
    output logic [1:0] HYST_LEVEL_OUT,
    output logic [1:0] POS_INPUT_SELECT_OUT,
    output logic [1:0] NEG_INPUT_SELECT_OUT,
    // Output pin, timer link and interrupt
    output logic CMP_OUT_PIN_OUT,
    output logic CMP_OUT_PIN_OE_OUT,
    output logic TIMER_LINK_OUT,
    output logic IRQ_OUT
);

    generate
        if (ADDR_W < 6 || ADDR_W > 32)
        begin : g_bad_addr
            $error("ADDR_W must be 6 to 32");
        end
    endgenerate

    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[4:2];
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a[ADDR_W-1:5] == '0);
    endfunction

    logic [7:0] cfg_ff;
    logic [1:0] pos_sel_ff;
    logic [1:0] neg_sel_ff;
    logic irq_en_ff;
    logic flag_ff;
    logic oper_ff;
    logic pin_ff;
    logic irq_ff;
    logic aw_hold_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic w_hold_ff;
    logic [7:0] w_byte_ff;
    logic w_lane0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic held;
    logic settled;
    logic rise;
    logic fall;

    // Field views
    wire cfg_enable = cfg_ff[CFG_ENABLE_BIT];
    wire cfg_pol = cfg_ff[CFG_POL_BIT];
    wire edge_mode_t mode = edge_mode_t'(cfg_ff[CFG_MODE_LSB +: 2]);

    // Write channel decode
    wire aw_take = S_AXI_AWVALID_IN && !aw_hold_ff;
    wire w_take = S_AXI_WVALID_IN && !w_hold_ff;
    wire wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
    wire [2:0] wr_idx = reg_index(aw_addr_ff);
    wire wr_ok = addr_mapped(aw_addr_ff);
    wire wr_lane = wr_fire && wr_ok && w_lane0_ff;
    wire wr_cfg = wr_lane && (wr_idx == IDX_CONFIG);
    wire wr_route = wr_lane && (wr_idx == IDX_ROUTE);
    wire wr_irqen = wr_lane && (wr_idx == IDX_IRQEN);
    wire wr_stat = wr_lane && (wr_idx == IDX_STATUS);
    wire route_accept = wr_route && !cfg_enable;
    wire flag_clear = wr_stat && w_byte_ff[STAT_FLAG_BIT];

    // Read channel decode
    wire ar_take = S_AXI_ARVALID_IN && !rvalid_ff;
    wire [2:0] rd_idx = reg_index(S_AXI_ARADDR_IN);
    wire rd_ok = addr_mapped(S_AXI_ARADDR_IN);
    wire [7:0] route_view = (8'(pos_sel_ff) << ROUTE_POS_LSB) | (8'(neg_sel_ff) << ROUTE_NEG_LSB);
    wire [7:0] irqen_view = 8'(irq_en_ff) << IRQEN_BIT;
    wire [7:0] stat_view = (8'(held) << STAT_RESULT_BIT) | (8'(flag_ff) << STAT_FLAG_BIT);
    wire [7:0] rd_byte = !rd_ok ? 8'h00 :
        (rd_idx == IDX_CONFIG) ? cfg_ff :
        (rd_idx == IDX_ROUTE) ? route_view :
        (rd_idx == IDX_IRQEN) ? irqen_view :
        (rd_idx == IDX_STATUS) ? stat_view : 8'h00;

    wire set_event = ((mode == EDGE_RISE) && rise) || ((mode == EDGE_FALL) && fall)
        || ((mode == EDGE_BOTH) && (rise || fall));
    // Set wins over a same-cycle clear
    wire nxt_flag = set_event || (flag_ff && !flag_clear);
    wire nxt_oper = cfg_enable && !STOP_MODE_IN;
    wire nxt_pin = oper_ff ? (held ^ cfg_pol) : cfg_pol;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            aw_hold_ff <= 1'b0;
            aw_addr_ff <= '0;
        end
        else if (aw_take)
        begin
            aw_hold_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_IN;
        end
        else if (wr_fire)
            aw_hold_ff <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            w_hold_ff <= 1'b0;
            w_byte_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
        end
        else if (w_take)
        begin
            w_hold_ff <= 1'b1;
            w_byte_ff <= S_AXI_WDATA_IN[7:0];
            w_lane0_ff <= S_AXI_WSTRB_IN[0];
        end
        else if (wr_fire)
            w_hold_ff <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_BREADY_IN)
            bvalid_ff <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_byte};
            rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RREADY_IN)
            rvalid_ff <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            cfg_ff <= CONFIG_RST;
        else if (wr_cfg)
            cfg_ff <= w_byte_ff;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            pos_sel_ff <= SEL_RST;
            neg_sel_ff <= SEL_RST;
        end
        else if (route_accept)
        begin
            pos_sel_ff <= w_byte_ff[ROUTE_POS_LSB +: 2];
            neg_sel_ff <= w_byte_ff[ROUTE_NEG_LSB +: 2];
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            irq_en_ff <= IRQEN_RST;
        else if (wr_irqen)
            irq_en_ff <= w_byte_ff[IRQEN_BIT];
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            flag_ff <= 1'b0;
            oper_ff <= 1'b0;
            pin_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            flag_ff <= nxt_flag;
            oper_ff <= nxt_oper;
            pin_ff <= nxt_pin;
            irq_ff <= flag_ff && irq_en_ff;
        end
    end

    cmp_result_path #(
        .CNT_W(7),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_path (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .raw_in(CMP_RAW_IN),
        .oper_in(oper_ff),
        .held_out(held),
        .settled_out(settled),
        .rise_out(rise),
        .fall_out(fall)
    );

    assign S_AXI_AWREADY_OUT = !aw_hold_ff;
    assign S_AXI_WREADY_OUT = !w_hold_ff;
    assign S_AXI_BVALID_OUT = bvalid_ff;
    assign S_AXI_BRESP_OUT = bresp_ff;
    assign S_AXI_ARREADY_OUT = !rvalid_ff;
    assign S_AXI_RVALID_OUT = rvalid_ff;
    assign S_AXI_RDATA_OUT = rdata_ff;
    assign S_AXI_RRESP_OUT = rresp_ff;
    assign CMP_POWER_OUT = oper_ff;
    assign INPUT_CONNECT_OUT = cfg_enable;
    assign FILTER_SPEED_OUT = cfg_ff[CFG_FSPEED_BIT];
    assign HYST_LEVEL_OUT = cfg_ff[CFG_HYST_LSB +: 2];
    assign POS_INPUT_SELECT_OUT = pos_sel_ff;
    assign NEG_INPUT_SELECT_OUT = neg_sel_ff;
    assign CMP_OUT_PIN_OUT = pin_ff;
    assign CMP_OUT_PIN_OE_OUT = cfg_ff[CFG_PIN_EN_BIT];
    assign TIMER_LINK_OUT = held;
    assign IRQ_OUT = irq_ff;

    // Checks
    localparam int LAG = FLAG_LAG_CYCLES;
    logic [7:0] age_ff;

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            age_ff <= 8'h00;
        else if (!oper_ff)
            age_ff <= 8'h00;
        else if (age_ff != 8'hff)
            age_ff <= age_ff + 8'h01;
    end

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);

    property p_oper_follows;
        (cfg_enable && !STOP_MODE_IN) |=> oper_ff ##0 CMP_POWER_OUT;
    endproperty
    a_oper_follows: assert property (p_oper_follows) else $error("not operational");

    property p_hold_off;
        !oper_ff |=> $stable(held);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("state changed in shutdown");

    property p_shut_zero;
        (!oper_ff && !cfg_pol)[*2] |-> (CMP_OUT_PIN_OUT == 1'b0);
    endproperty
    a_shut_zero: assert property (p_shut_zero) else $error("pin not zero in shutdown");

    property p_settle_len;
        settled == (age_ff >= 8'(SETTLE_CYC));
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

    property p_settle_hold;
        !settled |=> $stable(held);
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("result moved while settling");

    property p_pin_en;
        wr_cfg |=> (CMP_OUT_PIN_OE_OUT == $past(w_byte_ff[CFG_PIN_EN_BIT]));
    endproperty
    a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");

    property p_polarity;
        (oper_ff && $past(oper_ff)) |-> (CMP_OUT_PIN_OUT == ($past(held) ^ $past(cfg_pol)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

    property p_mode_none;
        (mode == EDGE_NONE) && !flag_ff |=> !flag_ff;
    endproperty
    a_mode_none: assert property (p_mode_none) else $error("flag set with mode none");

    property p_route_lock;
        (wr_route && cfg_enable) |=> ($stable(pos_sel_ff) && $stable(neg_sel_ff));
    endproperty
    a_route_lock: assert property (p_route_lock) else $error("route written while on");

    property p_flag_lag;
        ($rose(CMP_OUT_PIN_OUT) && $past(oper_ff) && $past(oper_ff, 2)
            && !$past(cfg_pol) && !$past(cfg_pol, 2) && (mode == EDGE_RISE))
            ##1 (mode == EDGE_RISE) |-> ##(LAG - 1) flag_ff;
    endproperty
    a_flag_lag: assert property (p_flag_lag) else $error("flag lag wrong");

    property p_clear;
        (flag_clear && !set_event) |=> !flag_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_set_wins;
        (flag_clear && set_event) |=> flag_ff;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_irq;
        (flag_ff && irq_en_ff)[*2] |-> IRQ_OUT;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_rsvd_zero;
        (ar_take && rd_ok && (rd_idx >= IDX_RSVD_LO)) |=> (S_AXI_RDATA_OUT == 32'h0000_0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");

    c_settled: cover property ($rose(settled));
    c_flag: cover property ($rose(flag_ff) ##[1:4] flag_clear);
    c_route_refused: cover property (wr_route && cfg_enable);
    c_irq: cover property ($rose(IRQ_OUT));

endmodule

// [test/cmp_analog_model.sv]
`timescale 1ns/1ns
module cmp_analog_model
(
    // Clock and control from the block
    input wire logic clk_in,
    input wire logic power_in,
    input wire logic [1:0] pos_sel_in,
    input wire logic [1:0] neg_sel_in,
    // Node levels: int1, int0, ext1, ext0
    input wire logic [15:0] levels_in,
    // Raw decision
    output logic raw_out
);
    logic [3:0] pos_lvl;
    logic [3:0] neg_lvl;
    logic junk_ff = 1'b0;
    assign pos_lvl = levels_in[{pos_sel_in, 2'b00} +: 4];
    assign neg_lvl = levels_in[{neg_sel_in, 2'b00} +: 4];
    always_ff @(posedge clk_in)
    begin
        junk_ff <= ~junk_ff;
    end
    assign raw_out = power_in ? (pos_lvl > neg_lvl) : junk_ff;
endmodule

// [test/tb_comparator_control_logic.sv]
`timescale 1ns/1ns
module tb_comparator_control_logic
    import cmp_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic stop = 1'b0;
    logic [15:0] levels = 16'h0084;
    logic awready, wready, bvalid, arready, rvalid, raw;
    logic power, connect, fspeed, pin, pin_oe, link, irq;
    logic [1:0] bresp, rresp, hyst, pos_sel, neg_sel;
    logic [31:0] rdata, rv;
    logic [1:0] rs;
    int miscompares = 0;
    int n_compared = 0;

    comparator_control_logic #(.SETTLE_CYC(40)) dut_u (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .CMP_RAW_IN(raw), .STOP_MODE_IN(stop), .CMP_POWER_OUT(power),
        .INPUT_CONNECT_OUT(connect), .FILTER_SPEED_OUT(fspeed), .HYST_LEVEL_OUT(hyst),
        .POS_INPUT_SELECT_OUT(pos_sel), .NEG_INPUT_SELECT_OUT(neg_sel),
        .CMP_OUT_PIN_OUT(pin), .CMP_OUT_PIN_OE_OUT(pin_oe), .TIMER_LINK_OUT(link),
        .IRQ_OUT(irq));

    cmp_analog_model core_u (.clk_in(clk), .power_in(power), .pos_sel_in(pos_sel),
        .neg_sel_in(neg_sel), .levels_in(levels), .raw_out(raw));

    initial
    begin
        forever #5 clk = ~clk;
    end

    function automatic logic [11:0] ad(input logic [2:0] i);
        return {7'h00, i, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits end mid-cycle so registered outputs are settled when read
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Ready is sampled mid-cycle; it is flop based, so stable up to the edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic t_aw, t_w, t_b;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge clk);
            t_aw = awvalid && awready;
            t_w = wvalid && wready;
            t_b = bready && bvalid;
            if (t_b) rs = bresp;
            @(posedge clk);
            if (t_aw) awvalid <= 1'b0;
            if (t_w) wvalid <= 1'b0;
            if (t_b) bready <= 1'b0;
        end while (!t_b);
        @(negedge clk);
    endtask

    task automatic rd(input logic [11:0] a);
        logic t_ar, t_r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge clk);
            t_ar = arvalid && arready;
            t_r = rready && rvalid;
            rv = rdata;
            rs = rresp;
            @(posedge clk);
            if (t_ar) arvalid <= 1'b0;
            if (t_r) rready <= 1'b0;
        end while (!t_r);
        @(negedge clk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 8; i++)
        begin
            rchk(ad(3'(i)), 32'h0);
        end
        rd(12'h020);
        chk({30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(ad(IDX_RSVD_LO), 8'hff);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        rchk(ad(IDX_RSVD_LO), 32'h0);
        // Lane 0 strobe low: write must leave the register alone
        @(posedge clk);
        wstrb <= 4'h0;
        wr(ad(IDX_CONFIG), 8'hff);
        @(posedge clk);
        wstrb <= 4'h1;
        rchk(ad(IDX_CONFIG), 32'h0);
        wr(ad(IDX_STATUS), 8'h80);
        rchk(ad(IDX_STATUS), 32'h0);
    endtask

    task automatic t_config();
        wr(ad(IDX_CONFIG), 8'h7f);
        rchk(ad(IDX_CONFIG), 32'h7f);
        chk({28'h0, fspeed, hyst, pin_oe}, 32'hf);
        chk({30'h0, power, pin}, 32'h1);
        wr(ad(IDX_CONFIG), 8'h48);
        chk({29'h0, hyst, pin}, 32'h4);
        wr(ad(IDX_CONFIG), 8'h00);
        chk({31'h0, pin_oe}, 32'h0);
    endtask

    task automatic t_route();
        for (int i = 0; i < 4; i++)
        begin
            wr(ad(IDX_ROUTE), {2'b00, 2'(i), 2'b00, ~2'(i)});
            chk({28'h0, pos_sel, neg_sel}, {28'h0, 2'(i), ~2'(i)});
            rchk(ad(IDX_ROUTE), {26'h0, 2'(i), 2'b00, ~2'(i)});
        end
        wr(ad(IDX_CONFIG), 8'h80);
        wr(ad(IDX_ROUTE), 8'h11);
        rchk(ad(IDX_ROUTE), 32'h30);
        wr(ad(IDX_CONFIG), 8'h00);
        wr(ad(IDX_ROUTE), 8'h10);
        rchk(ad(IDX_ROUTE), 32'h10);
    endtask

    task automatic t_settle();
        wr(ad(IDX_CONFIG), 8'h81);
        chk({30'h0, power, connect}, 32'h3);
        rchk(ad(IDX_STATUS), 32'h0);
        chk({31'h0, link}, 32'h0);
        cyc(60);
        rchk(ad(IDX_STATUS), 32'h81);
        chk({31'h0, link}, 32'h1);
        wr(ad(IDX_IRQEN), 8'h01);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        wr(ad(IDX_STATUS), 8'h00);
        rchk(ad(IDX_STATUS), 32'h81);
        wr(ad(IDX_STATUS), 8'h01);
        rchk(ad(IDX_STATUS), 32'h80);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            wr(ad(IDX_CONFIG), 8'ha0 | 8'(m));
            @(posedge clk);
            levels <= 16'h0048;
            cyc(20);
            rchk(ad(IDX_STATUS), {31'h0, m[1]});
            chk({31'h0, pin}, 32'h1);
            wr(ad(IDX_STATUS), 8'h01);
            @(posedge clk);
            levels <= 16'h0084;
            cyc(20);
            rchk(ad(IDX_STATUS), {24'h0, 7'h40, m[0]});
            chk({31'h0, pin}, 32'h0);
            wr(ad(IDX_STATUS), 8'h01);
        end
    endtask

    task automatic t_stop();
        @(posedge clk);
        stop <= 1'b1;
        cyc(3);
        chk({31'h0, power}, 32'h0);
        @(posedge clk);
        levels <= 16'h0048;
        cyc(20);
        rchk(ad(IDX_STATUS), 32'h80);
        @(posedge clk);
        stop <= 1'b0;
        rchk(ad(IDX_STATUS), 32'h80);
        cyc(60);
        rchk(ad(IDX_STATUS), 32'h01);
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_config();
        t_route();
        t_settle();
        t_modes();
        t_stop();
        end_sim();
    end
endmodule
